// *** design/wdm_pkg.sv ***
`default_nettype none
package wdm_pkg;
    // Register word indices; byte address is index * 4
    localparam logic [7:0] MODE_INDEX = 8'h05;
    localparam logic [7:0] REFRESH_INDEX = 8'h0d;
    localparam logic [7:0] START_INDEX = 8'h0e;
    localparam logic [7:0] CTRL_INDEX = 8'h10;
    localparam logic [7:0] STATUS_INDEX = 8'h11;
    // Field positions
    localparam int ACTION_BIT = 2;
    localparam int PROTECT_BIT = 1;
    localparam int CSP_BIT = 7;
    // Reset values
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [13:0] COUNT_RESET = 14'h3fff;
    // Cycles after reset release before the option word is taken
    localparam logic [1:0] OPT_SETTLE = 2'h2;
    // Underflow initial values
    localparam logic [13:0] PERIOD_00 = 14'h03ff;
    localparam logic [13:0] PERIOD_01 = 14'h0fff;
    localparam logic [13:0] PERIOD_10 = 14'h1fff;
    localparam logic [13:0] PERIOD_11 = 14'h3fff;

    // Option word fields, sampled after reset release
    typedef struct packed {
        logic [1:0] refresh_window_sel;
        logic [1:0] underflow_period_sel;
    } wdm_option_type;

    // Watchdog outputs
    typedef struct packed {
        logic irq;
        logic rst;
    } wdm_event_type;
endpackage
`default_nettype wire

// *** design/wdm_counter.sv ***
`timescale 1ns/100ps
`default_nettype none
module wdm_counter (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // Control
    input wire logic tick_in,
    input wire logic start_in,
    input wire logic reload_in,
    input wire logic [13:0] init_in,
    // State
    output logic running_out,
    output logic underflow_out,
    output logic [13:0] count_out
);
    logic [13:0] count_q;
    logic [13:0] count_d;
    logic running_q;
    logic underflow_q;
    wire at_zero = (count_q == 14'h0000);
    wire step = running_q && tick_in;

    // Next count: reload wins over counting
    assign count_d = (start_in || reload_in || (step && at_zero)) ? init_in :
        (step ? count_q - 14'h0001 : count_q);

    // Counter and run state
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count_q <= wdm_pkg::COUNT_RESET;
            running_q <= 1'b0;
            underflow_q <= 1'b0;
        end else begin
            count_q <= count_d;
            underflow_q <= step && at_zero && !reload_in && !start_in;
            if (start_in) begin
                running_q <= 1'b1;
            end
        end
    end

    assign running_out = running_q;
    assign underflow_out = underflow_q;
    assign count_out = count_q;
endmodule
`default_nettype wire

// *** design/wdm_top.sv ***
// What this block does
// - Underflow period comes from a two-bit option field latched after reset.
// - Refresh window width comes from another two-bit option field.
// - Action bit 2 of mode register: 0 interrupt, 1 reset on underflow.
// - Action bit is sticky; writing 0 leaves a set bit at 1.
// - Enabling count source protection forces the action bit to 1.
// - Mode register writes take effect only with protect bit one set.
// - Mode register resets to zero; bits 3 to 6 read zero.
// - Period codes select 03FFh, 0FFFh, 1FFFh, 3FFFh initial values.
// - Window codes accept refresh in last 25, 50, 75 or 100 percent.
// - Any write to the start register with byte lane 0 selected starts the counter.
`timescale 1ns/100ps
`default_nettype none
module wdm_top (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // Wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // Option word, protection and count source tick inputs
    input wire logic [3:0] option_select_word_two_in,
    input wire logic protect_bit_one_in,
    input wire logic count_source_protect_enable_in,
    input wire logic count_tick_in,
    // Watchdog events
    output logic watchdog_irq_out,
    output logic watchdog_reset_out
);
    logic ack_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic action_q;
    logic [1:0] rsvd_lo_q;
    logic rsvd_hi_q;
    wdm_pkg::wdm_option_type opt_q;
    logic opt_taken_q;
    logic [1:0] opt_age_q;
    logic [3:0] opt_s1_q;
    logic [3:0] opt_s2_q;
    logic [1:0] prot_s1_q;
    logic [1:0] prot_s2_q;
    logic csp_prev_q;
    logic [1:0] tick_s_q;
    logic tick_prev_q;
    wdm_pkg::wdm_event_type evt_q;
    logic running;
    logic underflow;
    logic [13:0] count;

    // Period decode, used for reload and window
    function automatic logic [13:0] period_of(input logic [1:0] sel);
        unique case (sel)
            2'b00: period_of = wdm_pkg::PERIOD_00;
            2'b01: period_of = wdm_pkg::PERIOD_01;
            2'b10: period_of = wdm_pkg::PERIOD_10;
            2'b11: period_of = wdm_pkg::PERIOD_11;
        endcase
    endfunction

    // Bus decode
    wire req = wb_cyc_in && wb_stb_in && !ack_q;
    wire lane0 = wb_sel_in[0];
    wire wr = req && wb_we_in && lane0;
    wire [5:0] idx = wb_adr_in[7:2];

    // Register hits on the word index
    wire hit_mode = (idx == wdm_pkg::MODE_INDEX[5:0]);
    wire hit_ref = (idx == wdm_pkg::REFRESH_INDEX[5:0]);
    wire hit_start = (idx == wdm_pkg::START_INDEX[5:0]);
    wire hit_ctrl = (idx == wdm_pkg::CTRL_INDEX[5:0]);
    wire hit_stat = (idx == wdm_pkg::STATUS_INDEX[5:0]);

    // Synchronised protection levels
    wire prot_ok = prot_s2_q[0];
    wire csp_on = prot_s2_q[1];

    // Write strobes; a refused write is still acknowledged
    wire mode_wr = wr && hit_mode && prot_ok;
    wire start_wr = wr && hit_start;

    // Reload value from the latched period code
    wire [13:0] init_val = period_of(opt_q.underflow_period_sel);

    // Window limits as fractions of the period, shifts and one add
    wire [13:0] win_quarter = init_val >> 2;
    wire [13:0] win_half = init_val >> 1;
    wire [13:0] win_three = 14'(win_half + win_quarter);

    // Count at or below the limit is inside the window; 100% accepts always
    wire [13:0] win_lim = (opt_q.refresh_window_sel == 2'b11) ? init_val :
        (opt_q.refresh_window_sel == 2'b10) ? win_three :
        (opt_q.refresh_window_sel == 2'b01) ? win_half : win_quarter;
    wire in_window = (count <= win_lim);
    // Refresh outside counting or outside the window is dropped silently
    wire ref_wr = wr && hit_ref && running && in_window;

    // Count source tick, rising edge of the synchronised pin
    wire tick = tick_s_q[1] && !tick_prev_q;

    // Register read views
    wire [7:0] mode_view = {rsvd_hi_q, 4'h0, action_q, rsvd_lo_q};
    wire [31:0] ctrl_view = {28'h0000000, opt_q};
    wire [31:0] stat_view = {16'h0000, running, 1'b0, count};

    // Read mux; unmapped words read zero
    assign rdata_d = hit_mode ? {24'h000000, mode_view} :
        hit_ctrl ? ctrl_view :
        hit_stat ? stat_view : 32'h00000000;

    // Wishbone ack and read data
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q <= req;
            rdata_q <= rdata_d;
        end
    end

    // Option pin synchroniser
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            opt_s1_q <= 4'h0;
            opt_s2_q <= 4'h0;
        end else begin
            opt_s1_q <= option_select_word_two_in;
            opt_s2_q <= opt_s1_q;
        end
    end

    // Protect and count source protection synchroniser
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prot_s1_q <= 2'b00;
            prot_s2_q <= 2'b00;
        end else begin
            prot_s1_q <= {count_source_protect_enable_in, protect_bit_one_in};
            prot_s2_q <= prot_s1_q;
        end
    end

    // Tick synchroniser and edge history
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tick_s_q <= 2'b00;
            tick_prev_q <= 1'b0;
        end else begin
            tick_s_q <= {tick_s_q[0], count_tick_in};
            tick_prev_q <= tick_s_q[1];
        end
    end

    // Option word latched once, after the synchroniser has filled with pin data
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            opt_q <= '0;
            opt_taken_q <= 1'b0;
            opt_age_q <= 2'h0;
        end else if (!opt_taken_q) begin
            if (opt_age_q == wdm_pkg::OPT_SETTLE) begin
                opt_q <= opt_s2_q;
                opt_taken_q <= 1'b1;
            end else begin
                opt_age_q <= opt_age_q + 2'h1;
            end
        end
    end

    // Mode register
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            action_q <= wdm_pkg::MODE_RESET[wdm_pkg::ACTION_BIT];
            rsvd_lo_q <= wdm_pkg::MODE_RESET[1:0];
            rsvd_hi_q <= wdm_pkg::MODE_RESET[7];
            csp_prev_q <= 1'b0;
        end else begin
            csp_prev_q <= csp_on;
            if (csp_on && !csp_prev_q) begin
                action_q <= 1'b1;
            end else if (mode_wr && wb_dat_in[wdm_pkg::ACTION_BIT]) begin
                action_q <= 1'b1;
            end
            if (mode_wr) begin
                rsvd_lo_q <= wb_dat_in[1:0];
                rsvd_hi_q <= wb_dat_in[7];
            end
        end
    end

    // Underflow consequence
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            evt_q <= '0;
        end else begin
            evt_q.irq <= underflow && !action_q;
            evt_q.rst <= underflow && action_q;
        end
    end

    // Down counter with start and refresh reload
    wdm_counter u_counter (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .tick_in(tick),
        .start_in(start_wr),
        .reload_in(ref_wr),
        .init_in(init_val),
        .running_out(running),
        .underflow_out(underflow),
        .count_out(count)
    );

    // Outputs
    assign wb_ack_out = ack_q;
    assign wb_dat_out = rdata_q;
    assign watchdog_irq_out = evt_q.irq;
    assign watchdog_reset_out = evt_q.rst;
endmodule
`default_nettype wire

// *** dv/wdm_top_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module wdm_top_props (
    // Clock, reset and bus
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    // Watchdog pins
    input wire logic count_source_protect_enable_in,
    input wire logic count_tick_in,
    input wire logic watchdog_irq_out,
    input wire logic watchdog_reset_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    // Mode register read at its ack
    wire logic rd_m = wb_ack_out && !wb_we_in && wb_adr_in == 8'h14;
    logic seen_q;
    logic bit_q;
    logic [3:0] age_q;
    // Sticky history and cycles since a tick
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            seen_q <= 1'b0;
            bit_q <= 1'b0;
            age_q <= 4'hf;
        end else begin
            seen_q <= seen_q | watchdog_reset_out;
            bit_q <= bit_q | (rd_m & wb_dat_out[2]);
            age_q <= count_tick_in ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
        end
    end
    a_ack_follows: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("bus request not answered");
    a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    a_mode_zeros: assert property (rd_m |-> wb_dat_out[31:8] == 0 && wb_dat_out[6:3] == 0)
        else $error("unassigned mode bits not zero");
    a_one_event: assert property (!(watchdog_irq_out && watchdog_reset_out))
        else $error("irq and reset together");
    a_tick_cause: assert property ((watchdog_irq_out || watchdog_reset_out) |-> age_q < 4'hc)
        else $error("event without a tick");
    a_sticky_out: assert property (seen_q |-> !watchdog_irq_out)
        else $error("irq after reset action chosen");
    a_sticky_read: assert property (rd_m && bit_q |-> wb_dat_out[2])
        else $error("action bit cleared");
    a_csp_forces: assert property (rd_m && count_source_protect_enable_in &&
        $past(count_source_protect_enable_in, 8) |-> wb_dat_out[2])
        else $error("protection did not force action bit");
endmodule
bind wdm_top wdm_top_props u_props (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .count_source_protect_enable_in(count_source_protect_enable_in),
    .count_tick_in(count_tick_in), .watchdog_irq_out(watchdog_irq_out),
    .watchdog_reset_out(watchdog_reset_out));
`default_nettype wire

// *** dv/test_wdm_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_wdm_top;
    localparam logic [7:0] MODE = wdm_pkg::MODE_INDEX << 2;
    localparam logic [7:0] REFR = wdm_pkg::REFRESH_INDEX << 2;
    localparam logic [7:0] START = wdm_pkg::START_INDEX << 2;
    localparam logic [7:0] CTRL = wdm_pkg::CTRL_INDEX << 2;
    localparam logic [7:0] STAT = wdm_pkg::STATUS_INDEX << 2;
    logic clock_in = 1'b0, rst_b_in = 1'b0, cyc = 1'b0, we = 1'b0;
    logic prot = 1'b0, csp = 1'b0, tick = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] opt = 4'hc;
    logic [31:0] dat;
    logic ack, irq, wrst;
    logic [31:0] exp_q[$];
    int failures = 0, n_checks = 0, irq_cnt = 0, rst_cnt = 0;
    wdm_top dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .wb_cyc_in(cyc),
        .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf),
        .wb_dat_in(wdat), .wb_dat_out(dat), .wb_ack_out(ack),
        .option_select_word_two_in(opt), .protect_bit_one_in(prot),
        .count_source_protect_enable_in(csp), .count_tick_in(tick),
        .watchdog_irq_out(irq), .watchdog_reset_out(wrst));
    always #5 clock_in = ~clock_in;
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] e);
        n_checks++;
        if (seen !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", s, e, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clock_in);
        end while (ack !== 1'b1);
        cyc <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clock_in);
            tick <= 1'b1;
            repeat (2) @(posedge clock_in);
            tick <= 1'b0;
            repeat (2) @(posedge clock_in);
        end
    endtask
    task automatic rst(input logic [3:0] o);
        opt <= o;
        rst_b_in <= 1'b0;
        repeat (6) @(posedge clock_in);
        rst_b_in <= 1'b1;
        repeat (4) @(posedge clock_in);
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Read data against oldest note, event counts
    always @(posedge clock_in) begin
        if (ack === 1'b1 && we === 1'b0) chk("read", dat, exp_q.pop_front());
        irq_cnt += int'(irq === 1'b1);
        rst_cnt += int'(wrst === 1'b1);
    end
    // Hang guard
    initial begin
        #400us;
        failures++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'h2d75));
        rst(4'hc);
        rd(MODE, 32'h0);
        rd(CTRL, 32'hc);
        wb(1'b1, MODE, 32'h4);
        rd(MODE, 32'h0);
        wb(1'b1, 8'h7c, $urandom);
        rd(8'h7c, 32'h0);
        wb(1'b1, START, $urandom);
        rd(STAT, 32'h83ff);
        ticks(10);
        rd(STAT, 32'h83f5);
        wb(1'b1, REFR, $urandom);
        rd(STAT, 32'h83ff);
        ticks(1024);
        repeat (8) @(posedge clock_in);
        chk("events", {irq_cnt[15:0], rst_cnt[15:0]}, 32'h10000);
        prot <= 1'b1;
        repeat (4) @(posedge clock_in);
        wb(1'b1, MODE, 32'h4);
        rd(MODE, 32'h4);
        wb(1'b1, MODE, 32'h0);
        repeat (2) rd(MODE, 32'h4);
        prot <= 1'b0;
        rst(4'h1);
        wb(1'b1, START, $urandom);
        ticks(4);
        wb(1'b1, REFR, $urandom);
        rd(STAT, 32'h8ffb);
        csp <= 1'b1;
        repeat (8) @(posedge clock_in);
        rd(MODE, 32'h4);
        ticks(4092);
        repeat (8) @(posedge clock_in);
        chk("events", {irq_cnt[15:0], rst_cnt[15:0]}, 32'h10001);
        end_of_test();
    end
endmodule
`default_nettype wire
